// *** branch_call_breakpoint_unit.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Immediate branch sets PC to PC plus sign-extended long offset times four; four cycles.
// - Not-equal branch adds sign-extended short offset times four when registers differ.
// - Not-equal branch issues one cycle falling through, four cycles when taken.
// - Breakpoint saves PC to return register, copies enable to saved bit, clears enable.
// - Breakpoint vectors to debug base plus exception number times 32; four cycles.
// - Breakpoint return reloads PC from return register and restores the enable bit.
// - Register call writes PC plus four to link register, jumps to first register.
module branch_call_breakpoint_unit (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        instrValid,
   input  wire logic [2:0]  instrClass,
   input  wire logic [31:0] instrPc,
   input  wire logic [25:0] long_offset_field,
   input  wire logic [15:0] short_offset_field,
   input  wire logic [31:0] firstRegValue,
   input  wire logic [31:0] second_reg_field,
   input  wire logic [31:0] breakpointReturnIn,
   input  wire logic [31:0] debug_exception_base,
   output logic             redirect,
   output logic [31:0]      redirectPc,
   output logic             flushYounger,
   output logic             issueStall,
   output logic             linkWrite,
   output logic [31:0]      return_link_reg,
   output logic             breakpointReturnWrite,
   output logic [31:0]      breakpointReturnOut,
   output logic             breakpointException,
   output logic             interrupt_enable_bit,
   output logic             breakpoint_saved_enable
);

   // All state of the unit except the issue count lives in one record.
   typedef struct packed {
      logic        redirect;
      logic [31:0] redirectPc;
      logic        flushYounger;
      logic        linkWrite;
      logic [31:0] returnLink;
      logic        bpWrite;
      logic [31:0] bpOut;
      logic        bpException;
      logic        intEnable;
      logic        savedEnable;
      logic        stall;
   } unit_state_t;

   unit_state_t state;
   unit_state_t next_state;
   logic        counterBusy;
   logic        accept;
   logic        takeFour;
   logic [31:0] longDisp;
   logic [31:0] shortDisp;
   logic [31:0] vectorAddr;

   // Instructions are refused while a multi-cycle one is still issuing.
   assign accept = instrValid && !counterBusy;

   // Offsets shifted by two then sign-extended to a full word.
   assign longDisp  = {{4{long_offset_field[25]}}, long_offset_field,
                       2'h0};
   assign shortDisp = {{14{short_offset_field[15]}}, short_offset_field,
                       2'h0};
   // Vector spacing of 32 bytes per exception number.
   assign vectorAddr = debug_exception_base
                       + {22'h0, branch_call_pkg::BREAKPOINT_EXCEPTION_NUMBER,
                          5'h00};

   // Anything that redirects occupies the full issue window.
   always_comb begin
      takeFour = 1'b0;
      if (accept) begin
         unique case (instrClass)
            branch_call_pkg::OP_BRANCH_IMM: takeFour = 1'b1;
            branch_call_pkg::OP_BRANCH_NE:
               takeFour = (firstRegValue != second_reg_field);
            branch_call_pkg::OP_BREAK:      takeFour = 1'b1;
            branch_call_pkg::OP_BRET:       takeFour = 1'b1;
            branch_call_pkg::OP_CALL:       takeFour = 1'b1;
            default:                        takeFour = 1'b0;
         endcase
      end
   end

   issue_counter #(
      .WIDTH(3)
   ) u_issue (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .load     (takeFour),
      .loadValue(3'(branch_call_pkg::ISSUE_TAKEN_CYCLES)),
      .busy     (counterBusy)
   );

   // Decode one accepted instruction into its side effects; pulses last one cycle.
   always_comb begin
      next_state             = state;
      next_state.redirect    = 1'b0;
      next_state.flushYounger = 1'b0;
      next_state.linkWrite   = 1'b0;
      next_state.bpWrite     = 1'b0;
      next_state.bpException = 1'b0;
      next_state.stall       = counterBusy || takeFour;
      if (accept) begin
         unique case (instrClass)
            branch_call_pkg::OP_BRANCH_IMM: begin
               next_state.redirectPc = instrPc + longDisp;
               next_state.redirect   = 1'b1;
            end
            branch_call_pkg::OP_BRANCH_NE: begin
               if (firstRegValue != second_reg_field) begin
                  next_state.redirectPc = instrPc + shortDisp;
                  next_state.redirect   = 1'b1;
               end
            end
            branch_call_pkg::OP_BREAK: begin
               next_state.bpOut       = instrPc;
               next_state.bpWrite     = 1'b1;
               next_state.savedEnable = state.intEnable;
               next_state.intEnable   = 1'b0;
               next_state.bpException = 1'b1;
               next_state.redirectPc  = vectorAddr;
               next_state.redirect    = 1'b1;
            end
            branch_call_pkg::OP_BRET: begin
               next_state.redirectPc = breakpointReturnIn;
               next_state.intEnable  = state.savedEnable;
               next_state.redirect   = 1'b1;
            end
            branch_call_pkg::OP_CALL: begin
               next_state.returnLink = instrPc + branch_call_pkg::LINK_STEP;
               next_state.linkWrite  = 1'b1;
               next_state.redirectPc = firstRegValue;
               next_state.redirect   = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // A redirect kills the younger instructions already fetched.
      next_state.flushYounger = next_state.redirect;
   end

   // Interrupts come up enabled so software need not set the bit after reset.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state             <= '0;
         state.redirectPc  <= branch_call_pkg::PC_RESET;
         state.intEnable   <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign redirect               = state.redirect;
   assign redirectPc             = state.redirectPc;
   assign flushYounger           = state.flushYounger;
   assign issueStall             = state.stall;
   assign linkWrite              = state.linkWrite;
   assign return_link_reg        = state.returnLink;
   assign breakpointReturnWrite  = state.bpWrite;
   assign breakpointReturnOut    = state.bpOut;
   assign breakpointException    = state.bpException;
   assign interrupt_enable_bit   = state.intEnable;
   assign breakpoint_saved_enable = state.savedEnable;

   // Checks next to the logic they guard.
   a_imm_branch_target: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (accept && instrClass == branch_call_pkg::OP_BRANCH_IMM)
      |=> (redirect && redirectPc == $past(instrPc) + $past(longDisp)))
      else $error("Immediate branch target wrong.");

   a_bne_taken: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (accept && instrClass == branch_call_pkg::OP_BRANCH_NE
       && firstRegValue != second_reg_field)
      |=> (redirect && redirectPc == $past(instrPc) + $past(shortDisp)))
      else $error("Not-equal branch target wrong.");

   a_bne_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (accept && instrClass == branch_call_pkg::OP_BRANCH_NE
       && firstRegValue == second_reg_field) |=> (!redirect && !issueStall))
      else $error("Fall-through branch must not stall.");

   a_issue_four: assert property (@(posedge ref_clk) disable iff (sys_rst)
      takeFour |=> issueStall [*3] ##1 !counterBusy)
      else $error("Taken instruction must hold issue for four cycles.");

   a_break_save: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (accept && instrClass == branch_call_pkg::OP_BREAK)
      |=> (breakpointReturnWrite && breakpointReturnOut == $past(instrPc)
           && breakpoint_saved_enable == $past(interrupt_enable_bit)
           && !interrupt_enable_bit))
      else $error("Breakpoint state save wrong.");

   a_break_vector: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (accept && instrClass == branch_call_pkg::OP_BREAK)
      |=> (redirectPc == $past(debug_exception_base) + 32'h0000_0020))
      else $error("Breakpoint vector wrong.");

   a_bret_restore: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (accept && instrClass == branch_call_pkg::OP_BRET)
      |=> (redirectPc == $past(breakpointReturnIn)
           && interrupt_enable_bit == $past(breakpoint_saved_enable)))
      else $error("Breakpoint return wrong.");

   a_call_link: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (accept && instrClass == branch_call_pkg::OP_CALL)
      |=> (linkWrite && return_link_reg == $past(instrPc) + 32'h0000_0004
           && redirectPc == $past(firstRegValue)))
      else $error("Call link or target wrong.");

   a_flush_redirect: assert property (@(posedge ref_clk) disable iff (sys_rst)
      redirect |-> flushYounger)
      else $error("Redirect without flush.");

endmodule

// *** branch_call_pkg.sv ***
package branch_call_pkg;

   // Instruction classes handed over by the upstream decoder.
   localparam logic [2:0] OP_NONE      = 3'h0;
   localparam logic [2:0] OP_BRANCH_IMM = 3'h1;
   localparam logic [2:0] OP_BRANCH_NE = 3'h2;
   localparam logic [2:0] OP_BREAK     = 3'h3;
   localparam logic [2:0] OP_BRET      = 3'h4;
   localparam logic [2:0] OP_CALL      = 3'h5;

   // Issue cycle figures.
   localparam int ISSUE_TAKEN_CYCLES = 4;
   localparam int ISSUE_FALL_CYCLES  = 1;

   // Address arithmetic constants.
   localparam int OFFSET_SHIFT      = 2;
   localparam logic [31:0] LINK_STEP = 32'h0000_0004;
   localparam int VECTOR_SHIFT      = 5;

   // Reset value and breakpoint exception number.
   localparam logic [31:0] PC_RESET = 32'h0000_0000;
   localparam logic [4:0] BREAKPOINT_EXCEPTION_NUMBER = 5'h01;

   // Field widths.
   localparam int LONG_OFFSET_WIDTH  = 26;
   localparam int SHORT_OFFSET_WIDTH = 16;
   localparam int REG_INDEX_WIDTH    = 5;

endpackage

// *** issue_counter.sv ***
`timescale 1ns/100ps
// Counts the remaining issue cycles of a multi-cycle instruction.
module issue_counter #(
   parameter int WIDTH = 3
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic                  busy
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   initial begin
      if (WIDTH < 2) begin
         $error("issue_counter needs at least two bits");
      end
   end

   // Reload on a new instruction, otherwise count down to idle.
   always_comb begin
      next_count = count;
      if (load) begin
         next_count = loadValue;
      end else if (count != '0) begin
         next_count = count - WIDTH'(1);
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // Busy while cycles after the first remain.
   assign busy = (count > WIDTH'(1));

endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
   typedef struct {
      logic        red;
      logic [31:0] tgt;
      logic        lnk;
      logic [31:0] lnkV;
      logic        bpw;
      logic [31:0] bpV;
      logic        en;
      logic        sv;
      logic        stl;
   } note_t;
   logic        ref_clk, sys_rst, instrValid, redirect, flushYounger, issueStall;
   logic [2:0]  instrClass;
   logic [31:0] instrPc, firstRegValue, second_reg_field, breakpointReturnIn;
   logic [31:0] debug_exception_base, redirectPc, return_link_reg, breakpointReturnOut;
   logic [25:0] long_offset_field;
   logic [15:0] short_offset_field;
   logic        linkWrite, breakpointReturnWrite, breakpointException;
   logic        interrupt_enable_bit, breakpoint_saved_enable;
   note_t       notes[$];
   int          failures, samples_checked, cycles;
   logic [31:0] seed, tgtM, r1, r2;
   logic        enM, svM, due;

   branch_call_breakpoint_unit u_branch_call_breakpoint_unit (.*);

   // Free-running core clock.
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("Counts: %0d checked, %0d failed", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hold reset, then confirm the idle state of the enable bit, the saved bit and the target.
   task automatic do_reset();
      sys_rst = 1;
      enM = 1;
      svM = 0;
      tgtM = 0;
      repeat (12) @(negedge ref_clk);
      sys_rst = 0;
      check("enable", 32'(interrupt_enable_bit), 32'h1);
      check("saved", 32'(breakpoint_saved_enable), 32'h0);
      check("target", redirectPc, 32'h0);
   endtask

   // Presents one instruction and notes its expected answer; the gap after a four-cycle
   // operation is the minimum spacing, and with hold set the first two gap cycles carry refused
   // breakpoint requests, which must leave every port except issueStall untouched.
   task automatic send(input logic [2:0] cls, input logic [31:0] pc, a, b, ret, base,
                       input logic [25:0] lo, input logic [15:0] so, input logic hold);
      note_t n;
      {instrClass, instrPc, firstRegValue, second_reg_field} = {cls, pc, a, b};
      {breakpointReturnIn, debug_exception_base} = {ret, base};
      {long_offset_field, short_offset_field} = {lo, so};
      instrValid = 1;
      n = '{1'b1, tgtM, 1'b0, pc + 32'h4, 1'b0, pc, 1'b0, 1'b0, 1'b0};
      case (cls)
         branch_call_pkg::OP_BRANCH_IMM: n.tgt = pc + {{4{lo[25]}}, lo, 2'b00};
         branch_call_pkg::OP_BRANCH_NE: begin
            if (a !== b) n.tgt = pc + {{14{so[15]}}, so, 2'b00};
            else n.red = 0;
         end
         branch_call_pkg::OP_BREAK: begin
            n.tgt = base + 32'h20;
            n.bpw = 1;
            svM = enM;
            enM = 0;
         end
         branch_call_pkg::OP_BRET: begin
            n.tgt = ret;
            enM = svM;
         end
         branch_call_pkg::OP_CALL: begin
            n.tgt = a;
            n.lnk = 1;
         end
         default: n.red = 0;
      endcase
      tgtM = n.tgt;
      {n.en, n.sv} = {enM, svM};
      n.stl = n.red;
      notes.push_back(n);
      @(negedge ref_clk);
      if (n.red) begin
         if (hold) begin
            instrClass = branch_call_pkg::OP_BREAK;
            n = '{1'b0, tgtM, 1'b0, 32'h0, 1'b0, 32'h0, enM, svM, 1'b1};
            repeat (2) notes.push_back(n);
            repeat (2) @(negedge ref_clk);
         end
         instrValid = 0;
         repeat (hold ? 1 : 3) @(negedge ref_clk);
      end
   endtask

   // Each edge that sees a request registers its answer at that same edge, so the
   // outputs are read just after it settles, before the next edge replaces the pulses.
   always @(posedge ref_clk) begin
      note_t n;
      logic v;
      v = instrValid;
      due = v & ~sys_rst;
      #1;
      if (due && notes.size() > 0) begin
         n = notes.pop_front();
         check("redirect", 32'(redirect), 32'(n.red));
         check("flush", 32'(flushYounger), 32'(n.red));
         check("target", redirectPc, n.tgt);
         check("stall", 32'(issueStall), 32'(n.stl));
         check("link write", 32'(linkWrite), 32'(n.lnk));
         if (n.lnk) check("link", return_link_reg, n.lnkV);
         check("bp write", 32'(breakpointReturnWrite), 32'(n.bpw));
         check("bp exception", 32'(breakpointException), 32'(n.bpw));
         if (n.bpw) check("bp pc", breakpointReturnOut, n.bpV);
         check("enable", 32'(interrupt_enable_bit), 32'(n.en));
         check("saved", 32'(breakpoint_saved_enable), 32'(n.sv));
      end
   end

   // Cuts a hang short; the whole sequence needs well under a thousand cycles.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         $display("Run timed out");
         finish_test();
      end
   end

   initial begin
      {instrValid, instrClass, instrPc, long_offset_field, short_offset_field} = '0;
      {firstRegValue, second_reg_field, breakpointReturnIn, debug_exception_base} = '0;
      {failures, samples_checked, cycles, due} = '0;
      seed = 32'h2331070d;
      do_reset();
      send(3'h1, 32'h0000_1000, 0, 0, 0, 0, 26'h000_0010, 0, 0);
      send(3'h1, 32'h0000_1000, 0, 0, 0, 0, 26'h3ff_fffe, 0, 0);
      send(3'h1, 32'h8000_0000, 0, 0, 0, 0, 26'h200_0000, 0, 1);
      $display("Test done: immediate branch");
      send(3'h2, 32'h0000_3000, 5, 5, 0, 0, 0, 16'h8000, 0);
      send(3'h2, 32'h0000_3004, 5, 5, 0, 0, 0, 16'h0004, 0);
      send(3'h2, 32'h0000_3008, 1, 32'h8000_0001, 0, 0, 0, 16'hfffc, 0);
      send(3'h2, 32'h0000_300c, 6, 7, 0, 0, 0, 16'h7fff, 0);
      $display("Test done: not-equal branch");
      send(3'h3, 32'h0000_2000, 0, 0, 0, 32'h0001_0000, 0, 0, 0);
      send(3'h4, 32'h0000_4000, 0, 0, 32'h0000_2004, 0, 0, 0, 0);
      send(3'h3, 32'h0000_2100, 0, 0, 0, 32'hffff_ffe0, 0, 0, 0);
      send(3'h3, 32'h0000_2200, 0, 0, 0, 32'h0000_0800, 0, 0, 0);
      send(3'h4, 32'h0000_4004, 0, 0, 32'h0000_2204, 0, 0, 0, 0);
      send(3'h5, 32'hffff_fffc, 32'h0000_4000, 0, 0, 0, 0, 0, 0);
      $display("Test done: breakpoint and call");
      instrValid = 0;
      @(negedge ref_clk);
      do_reset();
      // Random mix; a coin flip forces equal operands so both not-equal paths recur.
      repeat (60) begin
         seed = lfsr(seed);
         r1 = lfsr(seed ^ 32'h5a5a_0f0f);
         r2 = seed[3] ? r1 : lfsr(r1);
         send(3'(seed % 6), seed, r1, r2, r1 ^ seed, r2, r1[25:0], seed[31:16], 0);
      end
      instrValid = 0;
      repeat (3) @(negedge ref_clk);
      $display("Test done: random mix");
      finish_test();
   end
endmodule
